// ---- design/flash_host_ctrl.sv ----
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What the document requires of the device and this block
// [RULE1] Sector erase selects sector by A19-A11
// [RULE2] Block erase selects block by A19-A15
// [RULE3] Device outputs only while selected and gated
// [RULE4] Device latches write data internally
// [RULE5] Width pin picks x8 or x16
// [RULE6] Hardware reset low returns array read
// [RULE7] Done pin low while program or erase
// [RULE8] Protect pin low guards outer sectors
// [RULE9] Keep hardware reset high in normal use
// [RULE10] Program: three unlock writes, then data
// [RULE11] Sector erase: six writes ending 50H
// [RULE12] Block erase: six writes ending 30H
// [RULE13] Chip erase: six writes ending 10H/555H
// [RULE14] B0H anywhere suspends erase
// [RULE15] 30H anywhere resumes erase
// [RULE16] Three writes ending 88H enter security-ID
// [RULE17] User ID program: A5H then data
// [RULE18] User ID lock: 85H then 0000H
// [RULE19] Three writes ending 90H enter bank ID
// [RULE20] CFI entry long or single 98H
// [RULE21] Exit long or single F0H
// [RULE22] Decoder compares A10-A0 and low byte
// [RULE23] A19-A18 carry the bank for ID/CFI
// [RULE24] Lock-out only in x16 mode
// [RULE25] Broken sequence is dropped by device
module flash_host_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [19:0] flash_addr,
  output logic             chip_sel_n,
  output logic             out_gate_n,
  output logic             write_strobe_n,
  output logic             hw_reset_n,
  output logic             protect_n,
  output logic             byte_mode_n,
  input  wire logic [14:0] dq_in,
  output logic      [14:0] dq_out,
  output logic             dq_oe,
  input  wire logic        top_data_or_low_addr_in,
  output logic             top_data_or_low_addr_out,
  output logic             top_data_or_low_addr_oe,
  input  wire logic        done_indicator_n
);
  localparam logic [7:0] SETUP_LD   = 8'(flash_host_pkg::SETUP_CYCLES - 1);
  localparam logic [7:0] WE_LOW_LD  = 8'(flash_host_pkg::WE_LOW_CYCLES - 1);
  localparam logic [7:0] RECOVER_LD = 8'(flash_host_pkg::RECOVER_CYCLES - 1);
  localparam logic [7:0] READ_LD    = 8'(flash_host_pkg::READ_CYCLES + flash_host_pkg::SYNC_CYCLES - 1);
  localparam logic [7:0] RST_LD     = 8'(flash_host_pkg::RST_LOW_CYCLES - 1);
  localparam int         WE_LOW_N   = int'(flash_host_pkg::WE_LOW_CYCLES);

  flash_host_pkg::state_e state_q;
  flash_host_pkg::op_e    op_q;
  logic [2:0]  step_q;
  logic        last_q;
  logic [7:0]  cnt_q;
  logic [20:0] tgt_q;
  logic [15:0] wdata_q;
  logic        byte_mode_q;
  logic        wp_release_q;
  logic        refused_q;
  logic [15:0] rdata_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [19:0] flash_addr_q;
  logic        ce_n_q;
  logic        oe_n_q;
  logic        we_n_q;
  logic        rst_n_q;
  logic [14:0] dq_out_q;
  logic        dq_oe_q;
  logic        top_out_q;
  logic        top_oe_q;
  logic [16:0] pins_sync;

  pin_sync #(
    .WIDTH     (17),
    .RESET_VAL (17'h1_0000)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({done_indicator_n, top_data_or_low_addr_in, dq_in}),
    .level   (pins_sync)
  );

  // Builds bus write number idx of a command; returns {last, address, data}.
  function automatic logic [36:0] cmd_step(input flash_host_pkg::op_e op, input logic [2:0] idx,
                                           input logic [19:0] tgt, input logic [15:0] wd);
    logic [19:0] a;
    logic [15:0] d;
    logic        last;
    logic        single;
    logic        three;
    a      = {9'h000, flash_host_pkg::ADDR_555};
    d      = {8'h00, flash_host_pkg::CODE_AA};
    last   = 1'b0;
    single = op inside {flash_host_pkg::OP_SUSPEND, flash_host_pkg::OP_RESUME,
                        flash_host_pkg::OP_CFI_SHORT, flash_host_pkg::OP_EXIT_SHORT};
    three  = op inside {flash_host_pkg::OP_SECID, flash_host_pkg::OP_IDENT,
                        flash_host_pkg::OP_CFI_LONG, flash_host_pkg::OP_EXIT_LONG};
    if (single) begin
      last = 1'b1;
      a    = tgt;
      case (op)
        flash_host_pkg::OP_SUSPEND: d = {8'h00, flash_host_pkg::CODE_B0}; // [RULE14]
        flash_host_pkg::OP_RESUME:  d = {8'h00, flash_host_pkg::CODE_30}; // [RULE15]
        flash_host_pkg::OP_CFI_SHORT: begin
          a = {tgt[19:18], 7'h00, flash_host_pkg::ADDR_055}; // [RULE20] [RULE23]
          d = {8'h00, flash_host_pkg::CODE_98};
        end
        default: d = {8'h00, flash_host_pkg::CODE_F0}; // [RULE21]
      endcase
    end else begin
      case (idx)
        3'd0: last = 1'b0;
        3'd1, 3'd4: begin
          a = {9'h000, flash_host_pkg::ADDR_2AA};
          d = {8'h00, flash_host_pkg::CODE_55};
        end
        3'd2: begin
          last = three;
          case (op)
            flash_host_pkg::OP_PROGRAM:  d = {8'h00, flash_host_pkg::CODE_A0}; // [RULE10]
            flash_host_pkg::OP_SECID:    d = {8'h00, flash_host_pkg::CODE_88}; // [RULE16]
            flash_host_pkg::OP_UID_PROG: d = {8'h00, flash_host_pkg::CODE_A5}; // [RULE17]
            flash_host_pkg::OP_UID_LOCK: d = {8'h00, flash_host_pkg::CODE_85}; // [RULE18]
            flash_host_pkg::OP_EXIT_LONG: d = {8'h00, flash_host_pkg::CODE_F0}; // [RULE21]
            flash_host_pkg::OP_IDENT: begin
              a = {tgt[19:18], 7'h00, flash_host_pkg::ADDR_555}; // [RULE19] [RULE23]
              d = {8'h00, flash_host_pkg::CODE_90};
            end
            flash_host_pkg::OP_CFI_LONG: begin
              a = {tgt[19:18], 7'h00, flash_host_pkg::ADDR_555}; // [RULE20] [RULE23]
              d = {8'h00, flash_host_pkg::CODE_98};
            end
            default: d = {8'h00, flash_host_pkg::CODE_80};
          endcase
        end
        3'd3: begin
          if (op inside {flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_UID_PROG, flash_host_pkg::OP_UID_LOCK}) begin
            last = 1'b1;
            a    = tgt; // [RULE10] [RULE17]
            d    = (op == flash_host_pkg::OP_UID_LOCK) ? flash_host_pkg::LOCK_DATA : wd; // [RULE18]
          end
        end
        default: begin
          last = 1'b1;
          case (op)
            flash_host_pkg::OP_SECT_ERASE: begin
              a = tgt; // [RULE11] [RULE1]
              d = {8'h00, flash_host_pkg::CODE_50};
            end
            flash_host_pkg::OP_BLK_ERASE: begin
              a = tgt; // [RULE12] [RULE2]
              d = {8'h00, flash_host_pkg::CODE_30};
            end
            default: d = {8'h00, flash_host_pkg::CODE_10}; // [RULE13]
          endcase
        end
      endcase
    end
    return {last, a, d};
  endfunction : cmd_step

  // APB decode; two-cycle access, pready comes from a flop.
  wire                    acc       = psel & penable;
  wire                    first_acc = acc & ~pready_q;
  wire                    wr_fire   = acc & pready_q & pwrite;
  wire                    sel_ctrl  = (paddr == flash_host_pkg::OFF_CTRL);
  wire                    sel_addr  = (paddr == flash_host_pkg::OFF_ADDR);
  wire                    sel_wdata = (paddr == flash_host_pkg::OFF_WDATA);
  wire                    sel_cfg   = (paddr == flash_host_pkg::OFF_CFG);
  wire                    sel_stat  = (paddr == flash_host_pkg::OFF_STATUS);
  wire                    mapped    = sel_ctrl | sel_addr | sel_wdata | sel_cfg | sel_stat;
  wire flash_host_pkg::op_e new_op  = flash_host_pkg::op_e'(pwdata[flash_host_pkg::CTRL_OP_LSB +: 4]);
  wire                    busy      = (state_q != flash_host_pkg::ST_IDLE);
  wire                    bad_lock  = (new_op == flash_host_pkg::OP_UID_LOCK) & byte_mode_q; // [RULE24]
  wire                    cmd_wr    = wr_fire & sel_ctrl;
  wire                    start     = cmd_wr & ~busy & ~bad_lock;
  wire                    refuse    = cmd_wr & (busy | bad_lock);
  wire                    clr_ref   = wr_fire & sel_stat & pwdata[flash_host_pkg::ST_REFUSED_BIT];
  wire [36:0]             first_wr  = cmd_step(new_op, 3'd0, tgt_q[19:0], wdata_q);
  wire [36:0]             next_wr   = cmd_step(op_q, step_q + 3'd1, tgt_q[19:0], wdata_q);
  wire [31:0]             status_w  = {rdata_q, 13'h0000, refused_q, pins_sync[16], busy};
  wire [31:0] rd_mux = sel_ctrl  ? {28'h000_0000, op_q} :
                       sel_addr  ? {11'h000, tgt_q} :
                       sel_wdata ? {16'h0000, wdata_q} :
                       sel_cfg   ? {30'h0000_0000, wp_release_q, byte_mode_q} :
                       sel_stat  ? status_w : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
      prdata_q     <= 32'h0000_0000;
      tgt_q        <= flash_host_pkg::ADDR_RESET;
      wdata_q      <= flash_host_pkg::WDATA_RESET;
      byte_mode_q  <= flash_host_pkg::CFG_RESET[flash_host_pkg::CFG_BYTE_BIT];
      wp_release_q <= flash_host_pkg::CFG_RESET[flash_host_pkg::CFG_WP_BIT];
      refused_q    <= 1'b0;
    end else begin
      pready_q  <= first_acc;
      pslverr_q <= first_acc & ~mapped;
      prdata_q  <= (first_acc & ~pwrite) ? rd_mux : 32'h0000_0000;
      if (wr_fire & sel_addr) tgt_q <= pwdata[20:0];
      if (wr_fire & sel_wdata) wdata_q <= pwdata[15:0];
      // The width and protect pins must not move under a running sequence.
      if (wr_fire & sel_cfg & ~busy) begin
        byte_mode_q  <= pwdata[flash_host_pkg::CFG_BYTE_BIT];
        wp_release_q <= pwdata[flash_host_pkg::CFG_WP_BIT];
      end
      // A refusal in the same cycle as its clear stays set.
      refused_q <= refuse | (refused_q & ~clr_ref);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= flash_host_pkg::ST_IDLE;
      op_q         <= flash_host_pkg::OP_READ;
      step_q       <= 3'd0;
      last_q       <= 1'b0;
      cnt_q        <= 8'h00;
      rdata_q      <= 16'h0000;
      flash_addr_q <= 20'h0_0000;
      ce_n_q       <= 1'b1;
      oe_n_q       <= 1'b1;
      we_n_q       <= 1'b1;
      rst_n_q      <= 1'b1;
      dq_out_q     <= 15'h0000;
      dq_oe_q      <= 1'b0;
      top_out_q    <= 1'b0;
      top_oe_q     <= 1'b0;
    end else begin
      if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
      case (state_q)
        flash_host_pkg::ST_IDLE: begin
          top_oe_q  <= byte_mode_q;
          top_out_q <= tgt_q[flash_host_pkg::ADDR_LOW_BIT];
          if (start) begin
            op_q   <= new_op;
            step_q <= 3'd0;
            if (new_op == flash_host_pkg::OP_READ) begin
              flash_addr_q <= tgt_q[19:0];
              ce_n_q       <= 1'b0; // [RULE3]
              oe_n_q       <= 1'b0;
              cnt_q        <= READ_LD;
              state_q      <= flash_host_pkg::ST_READ;
            end else if (new_op == flash_host_pkg::OP_HW_RESET) begin
              rst_n_q <= 1'b0; // [RULE9]
              cnt_q   <= RST_LD;
              last_q  <= 1'b1;
              state_q <= flash_host_pkg::ST_RESET;
            end else begin
              flash_addr_q <= first_wr[35:16];
              dq_out_q     <= first_wr[14:0];
              top_out_q    <= byte_mode_q ? tgt_q[flash_host_pkg::ADDR_LOW_BIT] : first_wr[15];
              top_oe_q     <= 1'b1;
              dq_oe_q      <= 1'b1;
              last_q       <= first_wr[36];
              ce_n_q       <= 1'b0;
              cnt_q        <= SETUP_LD;
              state_q      <= flash_host_pkg::ST_SETUP;
            end
          end
        end
        flash_host_pkg::ST_SETUP: begin
          if (cnt_q == 8'h00) begin
            we_n_q  <= 1'b0;
            cnt_q   <= WE_LOW_LD;
            state_q <= flash_host_pkg::ST_STROBE;
          end
        end
        flash_host_pkg::ST_STROBE: begin
          // The device latches on the rising strobe, so data may be released afterwards.
          if (cnt_q == 8'h00) begin
            we_n_q  <= 1'b1;
            ce_n_q  <= 1'b1;
            cnt_q   <= RECOVER_LD;
            state_q <= flash_host_pkg::ST_RECOVER;
          end
        end
        flash_host_pkg::ST_RECOVER: begin
          if (cnt_q == 8'h00) begin
            if (last_q) begin
              dq_oe_q <= 1'b0;
              state_q <= flash_host_pkg::ST_IDLE;
            end else begin
              step_q       <= step_q + 3'd1;
              flash_addr_q <= next_wr[35:16];
              dq_out_q     <= next_wr[14:0];
              top_out_q    <= byte_mode_q ? tgt_q[flash_host_pkg::ADDR_LOW_BIT] : next_wr[15];
              last_q       <= next_wr[36];
              ce_n_q       <= 1'b0;
              cnt_q        <= SETUP_LD;
              state_q      <= flash_host_pkg::ST_SETUP;
            end
          end
        end
        flash_host_pkg::ST_READ: begin
          if (cnt_q == 8'h00) begin
            rdata_q <= byte_mode_q ? {8'h00, pins_sync[7:0]} : pins_sync[15:0];
            ce_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            state_q <= flash_host_pkg::ST_IDLE;
          end
        end
        default: begin
          if (cnt_q == 8'h00) begin
            rst_n_q <= 1'b1;
            cnt_q   <= RECOVER_LD;
            state_q <= flash_host_pkg::ST_RECOVER;
          end
        end
      endcase
    end
  end

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign flash_addr               = flash_addr_q;
  assign chip_sel_n               = ce_n_q;
  assign out_gate_n               = oe_n_q;
  assign write_strobe_n           = we_n_q;
  assign hw_reset_n               = rst_n_q;
  assign protect_n                = wp_release_q; // [RULE8]
  assign byte_mode_n              = ~byte_mode_q; // [RULE5]
  assign dq_out                   = dq_out_q;
  assign dq_oe                    = dq_oe_q;
  assign top_data_or_low_addr_out = top_out_q;
  assign top_data_or_low_addr_oe  = top_oe_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_only_cmd: assert property ($fell(rst_n_q) |-> $past(start) && op_q == flash_host_pkg::OP_HW_RESET) // [RULE9]
    else $error("hardware reset driven low outside a reset command");
  a_strobe_width: assert property ($fell(we_n_q) |-> !we_n_q ##(WE_LOW_N - 1) !we_n_q ##1 we_n_q) // [RULE10]
    else $error("write strobe low time wrong");
  a_strobe_chip: assert property (!we_n_q |-> !ce_n_q && oe_n_q && dq_oe_q) // [RULE3]
    else $error("write strobe without select or with output gate");
  a_unlock_first: assert property ($rose(busy) && step_q == 3'd0 && dq_oe_q && op_q inside {flash_host_pkg::OP_PROGRAM,
      flash_host_pkg::OP_SECT_ERASE, flash_host_pkg::OP_SECID} |-> flash_addr_q[10:0] == 11'h555 && dq_out_q[7:0] == 8'hAA) // [RULE11]
    else $error("first unlock write wrong");
  a_lock_wide: assert property ($rose(busy) && op_q == flash_host_pkg::OP_UID_LOCK |-> !byte_mode_q) // [RULE24]
    else $error("lock-out issued in byte mode");
  a_ident_bank: assert property ($fell(we_n_q) && op_q == flash_host_pkg::OP_IDENT && step_q == 3'd2
      |-> flash_addr_q[19:18] == tgt_q[19:18] && dq_out_q[7:0] == 8'h90) // [RULE19]
    else $error("bank address missing on identification entry");
  a_suspend_single: assert property ($rose(busy) && op_q == flash_host_pkg::OP_SUSPEND && dq_oe_q
      |-> dq_out_q[7:0] == 8'hB0 && last_q) // [RULE14]
    else $error("suspend not a single B0 write");
  a_apb_ready: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb ready not a single cycle after access");
endmodule : flash_host_ctrl
`default_nettype wire

// ---- design/flash_host_pkg.sv ----
package flash_host_pkg;

  // Register offsets on the APB side.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_CFG    = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Field positions.
  localparam int CTRL_OP_LSB    = 0;
  localparam int ADDR_LOW_BIT   = 20;
  localparam int CFG_BYTE_BIT   = 0;
  localparam int CFG_WP_BIT     = 1;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_READY_BIT   = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_RDATA_LSB   = 16;

  // Reset values.
  localparam logic [1:0]  CFG_RESET   = 2'h0;
  localparam logic [20:0] ADDR_RESET  = 21'h00_0000;
  localparam logic [15:0] WDATA_RESET = 16'h0000;

  // Command addresses (low eleven address bits only) and codes.
  localparam logic [10:0] ADDR_555 = 11'h555;
  localparam logic [10:0] ADDR_2AA = 11'h2AA;
  localparam logic [10:0] ADDR_055 = 11'h055;
  localparam logic [7:0]  CODE_AA  = 8'hAA;
  localparam logic [7:0]  CODE_55  = 8'h55;
  localparam logic [7:0]  CODE_A0  = 8'hA0;
  localparam logic [7:0]  CODE_80  = 8'h80;
  localparam logic [7:0]  CODE_50  = 8'h50;
  localparam logic [7:0]  CODE_30  = 8'h30;
  localparam logic [7:0]  CODE_10  = 8'h10;
  localparam logic [7:0]  CODE_B0  = 8'hB0;
  localparam logic [7:0]  CODE_88  = 8'h88;
  localparam logic [7:0]  CODE_A5  = 8'hA5;
  localparam logic [7:0]  CODE_85  = 8'h85;
  localparam logic [7:0]  CODE_90  = 8'h90;
  localparam logic [7:0]  CODE_98  = 8'h98;
  localparam logic [7:0]  CODE_F0  = 8'hF0;
  localparam logic [15:0] LOCK_DATA = 16'h0000;

  // Pin timing in ns and derived cycle counts (least times, rounded up).
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SETUP_NS      = 10;
  localparam int unsigned WE_LOW_NS     = 40;
  localparam int unsigned RECOVER_NS    = 30;
  localparam int unsigned READ_NS       = 70;
  localparam int unsigned RST_LOW_NS    = 500;
  localparam int unsigned SETUP_CYCLES   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_LOW_CYCLES  = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYCLES = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYCLES    = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_LOW_CYCLES = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_CYCLES    = 3;

  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_PROGRAM    = 4'h1,
    OP_SECT_ERASE = 4'h2,
    OP_BLK_ERASE  = 4'h3,
    OP_CHIP_ERASE = 4'h4,
    OP_SUSPEND    = 4'h5,
    OP_RESUME     = 4'h6,
    OP_SECID      = 4'h7,
    OP_UID_PROG   = 4'h8,
    OP_UID_LOCK   = 4'h9,
    OP_IDENT      = 4'hA,
    OP_CFI_LONG   = 4'hB,
    OP_CFI_SHORT  = 4'hC,
    OP_EXIT_LONG  = 4'hD,
    OP_EXIT_SHORT = 4'hE,
    OP_HW_RESET   = 4'hF
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETUP   = 3'b001,
    ST_STROBE  = 3'b011,
    ST_RECOVER = 3'b010,
    ST_READ    = 3'b110,
    ST_RESET   = 3'b100
  } state_e;

endpackage : flash_host_pkg

// ---- design/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int             WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] agree;

  // A bit only moves once the second and third stages agree, which filters single-cycle glitches.
  assign agree = ~(s2_q ^ s3_q);
  assign level = level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q    <= RESET_VAL;
      s2_q    <= RESET_VAL;
      s3_q    <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= (s3_q & agree) | (level_q & ~agree);
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- test/flash_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  input  wire logic [19:0] a,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic [15:0] d,
  output logic      [15:0] q,
  output wire logic        q_oe,
  output logic             pull_low
);
  logic [19:0] la [0:127];
  logic [15:0] ld [0:127];
  logic [15:0] mem [logic [19:0]];
  int          n = 0;
  int          resets = 0;
  logic        armed = 1'b0;
  wire         wr_on = !we_n && !ce_n;
  function automatic logic hit(int k, logic [10:0] ad, logic [7:0] c);
    return la[k][10:0] == ad && ld[k][7:0] == c;
  endfunction : hit
  assign q_oe = !ce_n && !oe_n && rst_n;
  initial begin
    q = 16'h0000;
    pull_low = 1'b0;
  end
  // Armed on a real write start, so the unknown-to-idle step at power-up is not taken as a write.
  always @(posedge wr_on) armed = 1'b1;
  always @(negedge wr_on) begin
    if (armed) begin
      la[n] = a;
      ld[n] = d;
      n++;
      if (n >= 4 && hit(n - 2, 11'h555, 8'hA0) && hit(n - 3, 11'h2AA, 8'h55) && hit(n - 4, 11'h555, 8'hAA)) begin
        mem[a] = d;
        pull_low = 1'b1;
      end
    end
  end
  always @(posedge pull_low) begin
    #400;
    pull_low = 1'b0;
  end
  always @(negedge rst_n) begin
    resets++;
    pull_low = 1'b0;
  end
  // The address moves in the same step as the output gate, so let it settle first.
  always @(negedge oe_n) #1 q = mem.exists(a) ? mem[a] : 16'hFFFF;
endmodule : flash_dev_model
`default_nettype wire

// ---- test/test_flash_host_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_flash_host_ctrl;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic [19:0] flash_addr;
  logic [14:0] dq_out;
  logic [15:0] m_q;
  logic        pready, pslverr, err, chip_sel_n, out_gate_n, write_strobe_n, hw_reset_n;
  logic        protect_n, byte_mode_n, dq_oe, top_out, top_oe, m_oe, m_low, x8_top = 1'b0;
  int          checked = 0;
  int          bad_count = 0;
  int          b;
  // A released bus shows the inverse of its last value, so a stale read cannot pass.
  wire  [14:0] dq_in  = dq_oe ? dq_out : m_oe ? m_q[14:0] : ~dq_out;
  wire         top_in = top_oe ? top_out : m_oe ? m_q[15] : ~top_out;
  flash_host_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .write_strobe_n(write_strobe_n), .hw_reset_n(hw_reset_n), .protect_n(protect_n),
    .byte_mode_n(byte_mode_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .top_data_or_low_addr_in(top_in), .top_data_or_low_addr_out(top_out),
    .top_data_or_low_addr_oe(top_oe), .done_indicator_n(!m_low));
  flash_dev_model dev_u (.a(flash_addr), .ce_n(chip_sel_n), .oe_n(out_gate_n), .we_n(write_strobe_n),
    .rst_n(hw_reset_n), .d({top_in, dq_in}), .q(m_q), .q_oe(m_oe), .pull_low(m_low));
  always #2 pclk = ~pclk;
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (pready !== 1'b1) bad_count++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic idle();
    for (int k = 0; k < 500; k++) begin
      apb(1'b0, flash_host_pkg::OFF_STATUS, 32'h0000_0000);
      if (rd[0] === 1'b0) break;
    end
    if (rd[0] !== 1'b0) bad_count++;
  endtask : idle
  task automatic seq(input flash_host_pkg::op_e op, input int nw, input logic [7:0] c3, input logic [19:0] ea,
                     input logic [15:0] ed);
    logic [19:0] a3;
    a3 = (op == flash_host_pkg::OP_IDENT || op == flash_host_pkg::OP_CFI_LONG) ? 20'hC_0555 : 20'h0_0555;
    b  = dev_u.n;
    apb(1'b1, flash_host_pkg::OFF_CTRL, {28'h000_0000, op});
    idle();
    chk(64'(dev_u.n - b), 64'(nw));
    for (int i = 0; i < nw - 1; i += 3) begin
      chk(64'({dev_u.la[b+i][10:0], dev_u.ld[b+i], dev_u.la[b+i+1][10:0], dev_u.ld[b+i+1]}),
          64'({11'h555, x8_top, 15'h00AA, 11'h2AA, x8_top, 15'h0055}));
    end
    if (nw >= 3) chk(64'({dev_u.la[b+2], dev_u.ld[b+2]}), 64'({a3, x8_top, 7'h00, c3}));
    if (nw != 3) chk(64'({dev_u.la[b+nw-1], dev_u.ld[b+nw-1]}), 64'({ea, ed}));
    $display("test op %h done", op);
  endtask : seq
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    #200_000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(64'({protect_n, byte_mode_n, hw_reset_n}), 64'(3'b011));
    apb(1'b0, flash_host_pkg::OFF_CFG, 32'h0000_0000);
    chk(64'(rd), 64'(flash_host_pkg::CFG_RESET));
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(64'({err, rd}), 64'({1'b1, 32'h0000_0000}));
    $display("test reset done");
    apb(1'b1, flash_host_pkg::OFF_ADDR, 32'h000C_5A8F);
    apb(1'b1, flash_host_pkg::OFF_WDATA, 32'h0000_BEEF);
    seq(flash_host_pkg::OP_PROGRAM, 4, 8'hA0, 20'hC_5A8F, 16'hBEEF);
    apb(1'b0, flash_host_pkg::OFF_STATUS, 32'h0000_0000);
    chk(64'(rd[1]), 64'(1'b0));
    apb(1'b1, flash_host_pkg::OFF_CTRL, 32'h0000_0000);
    idle();
    chk(64'(rd[31:16]), 64'(16'hBEEF));
    repeat (120) @(posedge pclk);
    apb(1'b0, flash_host_pkg::OFF_STATUS, 32'h0000_0000);
    chk(64'(rd[1]), 64'(1'b1));
    seq(flash_host_pkg::OP_SECT_ERASE, 6, 8'h80, 20'hC_5A8F, 16'h0050);
    seq(flash_host_pkg::OP_BLK_ERASE, 6, 8'h80, 20'hC_5A8F, 16'h0030);
    seq(flash_host_pkg::OP_CHIP_ERASE, 6, 8'h80, 20'h0_0555, 16'h0010);
    seq(flash_host_pkg::OP_SUSPEND, 1, 8'h00, 20'hC_5A8F, 16'h00B0);
    seq(flash_host_pkg::OP_RESUME, 1, 8'h00, 20'hC_5A8F, 16'h0030);
    seq(flash_host_pkg::OP_SECID, 3, 8'h88, 20'h0_0000, 16'h0000);
    seq(flash_host_pkg::OP_UID_PROG, 4, 8'hA5, 20'hC_5A8F, 16'hBEEF);
    seq(flash_host_pkg::OP_UID_LOCK, 4, 8'h85, 20'hC_5A8F, 16'h0000);
    seq(flash_host_pkg::OP_IDENT, 3, 8'h90, 20'h0_0000, 16'h0000);
    seq(flash_host_pkg::OP_CFI_LONG, 3, 8'h98, 20'h0_0000, 16'h0000);
    seq(flash_host_pkg::OP_CFI_SHORT, 1, 8'h00, 20'hC_0055, 16'h0098);
    seq(flash_host_pkg::OP_EXIT_LONG, 3, 8'hF0, 20'h0_0000, 16'h0000);
    seq(flash_host_pkg::OP_EXIT_SHORT, 1, 8'h00, 20'hC_5A8F, 16'h00F0);
    b = dev_u.n;
    apb(1'b1, flash_host_pkg::OFF_CTRL, 32'h0000_0001);
    apb(1'b1, flash_host_pkg::OFF_CTRL, 32'h0000_0006);
    idle();
    chk(64'({rd[2], dev_u.n - b}), 64'({1'b1, 32'd4}));
    apb(1'b1, flash_host_pkg::OFF_STATUS, 32'h0000_0004);
    apb(1'b1, flash_host_pkg::OFF_CFG, 32'h0000_0001);
    apb(1'b1, flash_host_pkg::OFF_ADDR, 32'h0010_0123);
    apb(1'b1, flash_host_pkg::OFF_WDATA, 32'h0000_12C3);
    x8_top = 1'b1;
    seq(flash_host_pkg::OP_PROGRAM, 4, 8'hA0, 20'h0_0123, 16'h92C3);
    chk(64'(byte_mode_n), 64'(1'b0));
    b = dev_u.n;
    apb(1'b1, flash_host_pkg::OFF_CTRL, 32'h0000_0009);
    idle();
    chk(64'({rd[2], dev_u.n - b}), 64'({1'b1, 32'd0}));
    apb(1'b1, flash_host_pkg::OFF_STATUS, 32'h0000_0004);
    apb(1'b1, flash_host_pkg::OFF_CFG, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(64'({protect_n, byte_mode_n}), 64'(2'b11));
    b = dev_u.resets;
    apb(1'b1, flash_host_pkg::OFF_CTRL, 32'h0000_000F);
    idle();
    chk(64'({hw_reset_n, dev_u.resets - b}), 64'({1'b1, 32'd1}));
    $display("test pins done");
    conclude();
  end
endmodule : test_flash_host_ctrl
`default_nettype wire
